//--- hdl/carry_port_return_ops.v
// Purpose: Executes clear-carry, clear-port-bit, subroutine return and interrupt return.
// Assumes: Instructions are issued by software through the AXI4-Lite slave.
// Notes: Saved interrupt state is loaded by software through the save registers.
`include "carry_port_return_map.vh"
`timescale 1ns/1ps
`default_nettype none
module carry_port_return_ops #(
   parameter PC_W      = 10,
   parameter SP_W      = 3,
   parameter PORT_BITS = 8
) (
   // Clock and reset
   input  wire        aclk,
   input  wire        aresetn,
   // AXI4-Lite write channels
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // AXI4-Lite read channels
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // Core state outputs
   output reg  [PORT_BITS-1:0] port_out,
   output reg                  carry_flag,
   output reg  [PC_W-1:0]      pc_out,
   output wire                 busy
);
   localparam ST_IDLE = 2'b01;
   localparam ST_RET2 = 2'b10;
   localparam DEPTH   = 1 << SP_W;

   reg [1:0]      state_reg;
   reg [SP_W-1:0] stack_pointer;
   reg [PC_W-1:0] return_stack [0:DEPTH-1];
   reg [PC_W-1:0] ret_target_reg;
   reg [3:0]      ptr_x_reg, ptr_y_reg, ptr_z_reg, idx_reg;
   reg [3:0]      sav_x_reg, sav_y_reg, sav_z_reg;
   reg            sav_carry_reg, sav_skip_reg, sav_nop_reg;
   reg            skip_reg, nop_mode_reg, in_isr_reg, bad_op_reg;
   reg [7:0]      aw_addr_reg;
   reg [31:0]     w_data_reg;
   reg [3:0]      w_strb_reg;
   reg            aw_have_reg, w_have_reg;
   reg [31:0]     rd_val;
   reg            rd_ok;
   integer        i;

   wire        do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;
   wire [31:0] wd       = w_data_reg;
   wire        wr_stack = (aw_addr_reg & `ADDR_STACK_MASK) == `ADDR_STACK_BASE;
   wire        wr_instr = do_write && aw_addr_reg == `ADDR_INSTR && w_strb_reg[0]
                          && state_reg == ST_IDLE;
   wire [9:0]  opcode   = wd[9:0];

   assign s_axi_awready = !aw_have_reg;
   assign s_axi_wready  = !w_have_reg;
   assign s_axi_arready = !s_axi_rvalid;
   assign busy          = state_reg != ST_IDLE;

   // Write channel capture, either order.
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_reg  <= 1'b0;
         w_have_reg   <= 1'b0;
         aw_addr_reg  <= 8'h00;
         w_data_reg   <= 32'h0000_0000;
         w_strb_reg   <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `RESP_OKAY;
      end else begin
         if (s_axi_awvalid && !aw_have_reg) begin
            aw_have_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_have_reg) begin
            w_have_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_have_reg  <= 1'b0;
            w_have_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr_reg == `ADDR_CONTROL || aw_addr_reg == `ADDR_INSTR
                             || aw_addr_reg == `ADDR_PC || aw_addr_reg == `ADDR_PORT
                             || aw_addr_reg == `ADDR_SAVE_PTR
                             || aw_addr_reg == `ADDR_SAVE_FLAGS || wr_stack)
                            ? `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Instruction execution and core state.
   always @(posedge aclk) begin
      if (!aresetn) begin
         state_reg      <= ST_IDLE;
         stack_pointer  <= {SP_W{1'b0}};
         ret_target_reg <= {PC_W{1'b0}};
         pc_out         <= {PC_W{1'b0}};
         port_out       <= {PORT_BITS{1'b0}};
         carry_flag     <= 1'b0;
         {ptr_x_reg, ptr_y_reg, ptr_z_reg, idx_reg} <= 16'h0000;
         {sav_x_reg, sav_y_reg, sav_z_reg} <= 12'h000;
         {sav_carry_reg, sav_skip_reg, sav_nop_reg} <= 3'b000;
         {skip_reg, nop_mode_reg, in_isr_reg, bad_op_reg} <= 4'h0;
         for (i = 0; i < DEPTH; i = i + 1)
            return_stack[i] <= {PC_W{1'b0}};
      end else begin
         if (state_reg == ST_RET2) begin
            pc_out        <= ret_target_reg;
            stack_pointer <= stack_pointer - 1'b1;
            state_reg     <= ST_IDLE;
         end
         if (do_write && aw_addr_reg == `ADDR_PC) begin
            pc_out        <= wd[PC_W-1:0];
            stack_pointer <= wd[16+SP_W-1:16];
         end
         if (do_write && aw_addr_reg == `ADDR_PORT)
            port_out <= wd[PORT_BITS-1:0];
         if (do_write && aw_addr_reg == `ADDR_SAVE_PTR) begin
            {sav_z_reg, sav_y_reg, sav_x_reg} <= wd[11:0];
            idx_reg <= wd[19:16];
         end
         if (do_write && aw_addr_reg == `ADDR_SAVE_FLAGS) begin
            {sav_nop_reg, sav_skip_reg, sav_carry_reg} <= wd[2:0];
            in_isr_reg <= wd[8];
         end
         if (do_write && wr_stack)
            return_stack[aw_addr_reg[SP_W+1:2]] <= wd[PC_W-1:0];
         if (wr_instr) begin
            bad_op_reg <= 1'b0;
            case (opcode)
               `OPC_CLEAR_CARRY: begin
                  carry_flag <= 1'b0;
                  skip_reg   <= 1'b0;
                  pc_out     <= pc_out + 1'b1;
               end
               `OPC_CLEAR_PORT_BIT: begin
                  if (idx_reg <= 4'h7)
                     port_out[idx_reg[2:0]] <= 1'b0;
                  else
                     bad_op_reg <= 1'b1;
                  pc_out <= pc_out + 1'b1;
               end
               `OPC_SUB_RETURN: begin
                  ret_target_reg <= return_stack[stack_pointer];
                  state_reg      <= ST_RET2;
               end
               `OPC_INT_RETURN: begin
                  pc_out        <= return_stack[stack_pointer];
                  stack_pointer <= stack_pointer - 1'b1;
                  in_isr_reg    <= 1'b0;
                  ptr_x_reg     <= sav_x_reg;
                  ptr_y_reg     <= sav_y_reg;
                  ptr_z_reg     <= sav_z_reg;
                  idx_reg       <= sav_y_reg;
                  carry_flag    <= sav_carry_reg;
                  skip_reg      <= sav_skip_reg;
                  nop_mode_reg  <= sav_nop_reg;
               end
               default: begin
                  bad_op_reg <= 1'b1;
               end
            endcase
         end
      end
   end

   // Read decode.
   always @* begin
      rd_val = 32'h0000_0000;
      rd_ok  = 1'b1;
      if ((s_axi_araddr & `ADDR_STACK_MASK) == `ADDR_STACK_BASE)
         rd_val[PC_W-1:0] = return_stack[s_axi_araddr[SP_W+1:2]];
      else begin
         case (s_axi_araddr)
            `ADDR_CONTROL:    rd_val[`CTRL_RUN_BIT] = busy;
            `ADDR_INSTR:      rd_val = 32'h0000_0000;
            `ADDR_PC:         rd_val = {{(16-SP_W){1'b0}}, stack_pointer,
                                        {(16-PC_W){1'b0}}, pc_out};
            `ADDR_STATUS:     rd_val = {23'h000000, bad_op_reg, in_isr_reg, nop_mode_reg,
                                        skip_reg, carry_flag, busy, 3'b000};
            `ADDR_PORT:       rd_val[PORT_BITS-1:0] = port_out;
            `ADDR_SAVE_PTR:   rd_val = {4'h0, idx_reg, ptr_z_reg, ptr_y_reg,
                                        ptr_x_reg, sav_z_reg, sav_y_reg, sav_x_reg};
            `ADDR_SAVE_FLAGS: rd_val = {23'h000000, in_isr_reg, 5'h00,
                                        sav_nop_reg, sav_skip_reg, sav_carry_reg};
            default:          rd_ok = 1'b0;
         endcase
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `RESP_OKAY;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_val;
         s_axi_rresp  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule
`default_nettype wire

//--- inc/carry_port_return_map.vh
// Purpose: Constants for the carry, port-bit and return instruction executor.
// Assumes: 10-bit instruction words, 10 MHz instruction clock.
// Notes: Register offsets are byte addresses on the AXI4-Lite slave.
// What this block does
// - The clear-output-bit operation drives to 0 the port bit chosen by the index register and leaves the others alone.
// - Only index values 0 to 7 are accepted, so eight port bits can be cleared this way.
// - The subroutine return reads the stack entry at the stack pointer in its first cycle, then loads the program counter and decrements the pointer in its second.
// - The interrupt return brings control back to the interrupted main routine and occupies one instruction word.
// - The interrupt return restores the saved data pointers, carry flag, pending skip and no-operation mode status.
`ifndef CARRY_PORT_RETURN_MAP_VH
`define CARRY_PORT_RETURN_MAP_VH
`define OPC_CLEAR_CARRY     10'h006
`define OPC_CLEAR_PORT_BIT  10'h014
`define OPC_SUB_RETURN      10'h044
`define OPC_INT_RETURN      10'h046
`define ADDR_CONTROL        8'h00
`define ADDR_INSTR          8'h04
`define ADDR_PC             8'h08
`define ADDR_STATUS         8'h0c
`define ADDR_PORT           8'h10
`define ADDR_SAVE_PTR       8'h14
`define ADDR_SAVE_FLAGS     8'h18
`define ADDR_STACK_BASE     8'h40
`define ADDR_STACK_MASK     8'hc0
`define CTRL_RUN_BIT        0
`define RESP_OKAY           2'b00
`define RESP_SLVERR         2'b10
`endif

//--- tb/carry_port_return_ops_checker.sv
// Purpose: Assertions on the instruction effects seen at the block's ports.
// Assumes: Address and data of an instruction write are taken at one edge.
// Notes: The saved carry is tracked from writes to the save-flags register.
`include "carry_port_return_map.vh"
`timescale 1ns/1ps
`default_nettype none
module carry_port_return_ops_checker #(
   parameter PORT_BITS = 8
) (
   // Clock, reset and write channels
   input wire logic                 aclk,
   input wire logic                 aresetn,
   input wire logic [7:0]           s_axi_awaddr,
   input wire logic                 s_axi_awvalid,
   input wire logic                 s_axi_awready,
   input wire logic [31:0]          s_axi_wdata,
   input wire logic                 s_axi_wvalid,
   input wire logic                 s_axi_wready,
   // Core state
   input wire logic [PORT_BITS-1:0] port_out,
   input wire logic                 carry_flag,
   input wire logic                 busy
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic saved_c_reg;
   wire  wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   always @(posedge aclk) begin
      if (!aresetn)
         saved_c_reg <= 1'b0;
      else if (wr_take && s_axi_awaddr == `ADDR_SAVE_FLAGS)
         saved_c_reg <= s_axi_wdata[0];
   end
   sequence op_s(logic [9:0] c);
      wr_take && s_axi_awaddr == `ADDR_INSTR && s_axi_wdata[9:0] == c && !busy;
   endsequence
   chk_carry_clear: assert property (op_s(`OPC_CLEAR_CARRY) |-> ##[1:2] !carry_flag)
      else $error("carry flag not cleared");
   chk_carry_only: assert property (op_s(`OPC_CLEAR_CARRY) |=> $stable(port_out)[*2])
      else $error("port changed on carry clear");
   chk_port_no_rise: assert property (op_s(`OPC_CLEAR_PORT_BIT) |=>
      ((port_out & ~$past(port_out)) == 0)[*2]) else $error("port bit set by clear");
   chk_port_one_bit: assert property (op_s(`OPC_CLEAR_PORT_BIT) |=>
      ($countones(port_out ^ $past(port_out)) <= 1)[*2]) else $error("several port bits moved");
   chk_sub_two: assert property (op_s(`OPC_SUB_RETURN) |-> ##[1:2] busy ##1 !busy)
      else $error("subroutine return length wrong");
   chk_int_done: assert property (op_s(`OPC_INT_RETURN) |-> ##3 !busy[*2])
      else $error("interrupt return still busy");
   chk_int_carry: assert property (op_s(`OPC_INT_RETURN) |-> ##[1:2] carry_flag == saved_c_reg)
      else $error("carry not restored");
endmodule
bind carry_port_return_ops carry_port_return_ops_checker #(.PORT_BITS(PORT_BITS)) chk (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .port_out(port_out),
   .carry_flag(carry_flag), .busy(busy));
`default_nettype wire

//--- tb/carry_port_return_ops_tb.sv
// Purpose: Self-checking bench for the carry, port-bit and return operations.
// Assumes: Registers and instructions are reached over AXI4-Lite only.
// Notes: Random values come from a fixed seed.
`include "carry_port_return_map.vh"
`timescale 1ns/1ps
`default_nettype none
module carry_port_return_ops_tb;
   logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
   logic        rready = 0;
   logic [7:0]  awaddr = 0, araddr = 0, p;
   logic [31:0] wdata = 0, rd, e, f;
   logic [9:0]  t;
   logic [2:0]  s;
   logic [1:0]  br, rr;
   wire         awready, wready, bvalid, arready, rvalid, busy, cy;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata;
   wire  [7:0]  port;
   wire  [9:0]  pc;
   int          fail_count = 0, samples_checked = 0;
   always #50 aclk = ~aclk;
   carry_port_return_ops DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .port_out(port),
      .carry_flag(cy), .pc_out(pc), .busy(busy));
   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
      end while (!bvalid);
      br = bresp;
      bready <= 0;
   endtask
   task automatic axr(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 0;
      end while (!rvalid);
      rd = rdata;
      rr = rresp;
      rready <= 0;
   endtask
   task automatic op(input logic [9:0] c);
      axw(`ADDR_INSTR, {22'h0, c});
      repeat (2) @(posedge aclk);
      while (busy) @(posedge aclk);
   endtask
   task automatic results;
      $display("checked %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      #2ms;
      fail_count++;
      results;
   end
   initial begin
      void'($urandom(32'h8ffc811d));
      repeat (5) @(posedge aclk);
      aresetn <= 1;
      for (int i = 0; i < 9; i++) begin
         p = $urandom;
         axw(`ADDR_PORT, {24'h0, p});
         axw(`ADDR_SAVE_PTR, i << 16);
         op(`OPC_CLEAR_PORT_BIT);
         check(port, i < 8 ? p & ~(8'h1 << i) : p);
      end
      axr(`ADDR_STATUS);
      check({br, rr, rd[8]}, {`RESP_OKAY, `RESP_OKAY, 1'b1});
      axw(8'h20, 32'h0);
      axr(8'h20);
      check({br, rr, rd}, {`RESP_SLVERR, `RESP_SLVERR, 32'h0});
      $display("port bit test done");
      axw(`ADDR_SAVE_FLAGS, 32'h1);
      op(`OPC_INT_RETURN);
      check(cy, 1'b1);
      t = $urandom;
      axw(`ADDR_PC, {13'h0, 3'h5, 6'h0, t});
      op(`OPC_CLEAR_CARRY);
      axr(`ADDR_PC);
      check({cy, port, rd}, {1'b0, p, 13'h0, 3'h5, 6'h0, t + 10'h1});
      $display("carry test done");
      for (int k = 0; k < 4; k++) begin
         s = $urandom;
         t = $urandom;
         e = $urandom & 32'hfff;
         f = k == 3 ? 32'h7 : $urandom & 32'h1;
         axw(`ADDR_STACK_BASE + {3'h0, s, 2'b00}, {22'h0, t});
         axw(`ADDR_SAVE_PTR, e);
         axw(`ADDR_SAVE_FLAGS, f);
         axw(`ADDR_PC, {13'h0, s, 16'h0});
         op(k[0] ? `OPC_INT_RETURN : `OPC_SUB_RETURN);
         axr(`ADDR_PC);
         check({pc, rd}, {t, 13'h0, s - 3'h1, 6'h0, t});
         if (k[0]) begin
            axr(`ADDR_SAVE_PTR);
            check(rd[27:12], {e[7:4], e[11:0]});
            axr(`ADDR_STATUS);
            check(rd[6:4], f[2:0]);
         end
      end
      $display("return test done");
      results;
   end
endmodule
`default_nettype wire
